// ==== logic/thrh_pkg.sv ====
// holds the constants and types shared by the halt/rats command handler
// assumes the rf modem checks crc_a and hands over whole bytes on the link clock
package thrh_pkg;

  // ****************************************************************
  // command codes and frame shape
  // ****************************************************************
  localparam logic [7:0] HLTA_CODE_HI  = 8'h50;  // first byte of halt command
  localparam logic [7:0] HLTA_CODE_LO  = 8'h00;  // second byte of halt command
  localparam logic [7:0] RATS_START    = 8'hE0;  // start byte of rats request
  localparam logic [2:0] CMD_FRAME_LEN = 3'h4;   // two data bytes plus two crc bytes
  localparam logic [2:0] RX_CNT_OVER   = 3'h5;   // marks a frame longer than four bytes
  localparam logic [3:0] CID_FORBIDDEN = 4'hF;   // logical address the reader may not use
  localparam logic [3:0] FSDI_STD_MAX  = 4'h8;   // last standard frame size code
  localparam logic [3:0] FSDI_256      = 4'hF;   // code that stands for 256 bytes

  // ****************************************************************
  // answer to select (ats)
  // ****************************************************************
  localparam logic [3:0] ATS_FWI  = 4'h4;   // frame waiting integer, fixed at design time (1..14)
  localparam logic [3:0] ATS_SFGI = 4'h0;   // no start-up guard time requested
  localparam logic [3:0] ATS_FSCI = 4'h8;   // tag frame size code, 256 bytes
  localparam logic [7:0] ATS_TL   = 8'h05;  // length incl. itself, crc excluded
  localparam logic [7:0] ATS_T0   = {4'h7, ATS_FSCI};  // 0x78: ta, tb, tc present
  localparam logic [7:0] ATS_TA   = 8'h80;  // same rate both ways, 106 kbps only
  localparam logic [7:0] ATS_TB   = {ATS_FWI, ATS_SFGI};
  localparam logic [7:0] ATS_TC   = 8'h00;  // neither cid nor nad supported
  localparam logic [2:0] ATS_LAST = 3'h4;   // index of the last ats byte, no history bytes

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int QUIET_TIME_US = 1000;  // silence after halt, in microseconds
  localparam int CLK_MHZ       = 40;
  localparam int QUIET_CYCLES  = QUIET_TIME_US * CLK_MHZ;  // a least time, exact here

  // ****************************************************************
  // register port
  // ****************************************************************
  localparam logic [1:0] REG_CTRL   = 2'h0;  // bit0 enables the handler
  localparam logic [1:0] REG_STATUS = 2'h1;  // state, quiet, sending
  localparam logic [1:0] REG_PARAM  = 2'h2;  // fsdi and cid as received
  localparam logic [7:0] CTRL_RESET = 8'h01;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HALT,
    ST_ACTIVE,
    ST_PROTOCOL
  } thrh_state_type;

  typedef struct packed {
    logic       link_clk;
    logic       byte_vld;
    logic       frame_end;
    logic       crc_ok;
    logic [7:0] data;
  } thrh_link_type;

  localparam thrh_link_type LINK_RESET = '{default: '0};

endpackage

// ==== logic/thrh_link_sync.sv ====
// three-stage synchroniser for the link inputs and link clock edge finder
// assumes link inputs change around the link clock and stay put for a whole link period
`timescale 1ns/1ps
`default_nettype none

module thrh_link_sync
  import thrh_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire thrh_link_type link_raw,
  output var  thrh_link_type link_stable,
  output var  logic          link_rise
);

  thrh_link_type s1_ff;
  thrh_link_type s2_ff;
  thrh_link_type s3_ff;

  // ****************************************************************
  // synchroniser chain
  // ****************************************************************
  // stage one feeds stage two only, to let metastability settle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= LINK_RESET;
      s2_ff <= LINK_RESET;
      s3_ff <= LINK_RESET;
    end else begin
      s1_ff <= link_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // ****************************************************************
  // accepted value and clock edge
  // ****************************************************************
  // a bit changes only once stages two and three agree, filtering one-cycle glitches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_stable <= LINK_RESET;
      link_rise   <= 1'b0;
    end else begin
      link_stable <= (s2_ff & ~(s2_ff ^ s3_ff)) | (link_stable & (s2_ff ^ s3_ff));
      link_rise   <= (s2_ff.link_clk & s3_ff.link_clk) & ~link_stable.link_clk;
    end
  end

endmodule

`default_nettype wire

// ==== logic/thrh_handler.sv ====
// halt and rats command handler of a type a contactless tag
// assumes the modem gives bytes, frame end and crc verdict on the link clock,
// appends crc_a to what is sent here, and that select logic pulses SELECTED on SYS_CLK
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE_01: halt frame 0x5000 plus crc enters halt
// RULE_02: silent at least 1 ms after halt
// RULE_03: rats recognised by start byte 0xE0
// RULE_04: upper parameter nibble gives reader frame size
// RULE_05: fsdi 0x9 to 0xE treated as 0xF
// RULE_06: lower parameter nibble kept as cid
// RULE_07: cid 15 gets no answer, back idle
// RULE_08: ats length byte is 0x05
// RULE_09: ats format byte is 0x78
// RULE_10: ta(1) is 0x80, 106 kbps symmetric
// RULE_11: tb(1) holds fwi and sfgi zero
// RULE_12: reader waits start-up guard time after ats
// RULE_13: tc(1) is 0x00, no cid/nad
// RULE_14: no history bytes, crc follows tc(1)
// RULE_15: bad crc frames dropped, state kept
// RULE_16: fwi is a fixed design constant
module thrh_handler
  import thrh_pkg::*;
#(
  parameter int QUIET_CNT = QUIET_CYCLES
)
(
  input  wire logic           SYS_CLK,
  input  wire logic           RST_N,
  input  wire logic           LINK_CLK,
  input  wire logic [7:0]     RX_BYTE,
  input  wire logic           RX_BYTE_VLD,
  input  wire logic           RX_FRAME_END,
  input  wire logic           RX_CRC_OK,
  input  wire logic           SELECTED,
  input  wire logic [1:0]     REG_ADDR,
  input  wire logic [7:0]     REG_WDATA,
  input  wire logic           REG_WR,
  input  wire logic           REG_RD,
  output var  logic [7:0]     REG_RDATA,
  output var  logic [7:0]     TX_BYTE,
  output var  logic           TX_VLD,
  output var  logic           TX_LAST,
  output var  logic           TX_QUIET,
  output var  thrh_state_type TAG_STATE,
  output var  logic [3:0]     CID,
  output var  logic [8:0]     FSD_BYTES
);

  thrh_link_type  link_raw;
  thrh_link_type  link;
  logic           link_rise;
  logic [7:0]     rx_buf_ff [CMD_FRAME_LEN];
  logic [2:0]     rx_cnt_ff;
  logic           is_hlta;
  logic           is_rats;
  logic           frame_done;
  logic [7:0]     ctrl_ff;
  logic [7:0]     param_ff;
  logic [31:0]    quiet_cnt_ff;
  logic           tx_busy_ff;
  logic           tx_start_ff;
  logic [2:0]     tx_idx_ff;

  // ****************************************************************
  // functions
  // ****************************************************************
  // frame size in bytes for an fsdi or fsci code
  function automatic logic [8:0] fsd_of(input logic [3:0] code);
    logic [8:0] size;
    size = 9'h100;
    case (code)
      4'h0: size = 9'h010;
      4'h1: size = 9'h018;
      4'h2: size = 9'h020;
      4'h3: size = 9'h028;
      4'h4: size = 9'h030;
      4'h5: size = 9'h040;
      4'h6: size = 9'h060;
      4'h7: size = 9'h080;
      default: size = 9'h100;  // 0x8, 0xF and the reserved codes
    endcase
    return size;
  endfunction

  // byte of the answer to select at a given index
  function automatic logic [7:0] ats_byte(input logic [2:0] idx);
    logic [7:0] b;
    case (idx)
      3'h0: b = ATS_TL;     // [RULE_08]
      3'h1: b = ATS_T0;     // [RULE_09]
      3'h2: b = ATS_TA;     // [RULE_10]
      3'h3: b = ATS_TB;     // [RULE_11] [RULE_16]
      default: b = ATS_TC;  // [RULE_13]
    endcase
    return b;
  endfunction

  // ****************************************************************
  // link input synchronisation
  // ****************************************************************
  assign link_raw = '{link_clk: LINK_CLK, byte_vld: RX_BYTE_VLD, frame_end: RX_FRAME_END,
                      crc_ok: RX_CRC_OK, data: RX_BYTE};

  thrh_link_sync u_sync (
    .clk         (SYS_CLK),
    .rst_n       (RST_N),
    .link_raw    (link_raw),
    .link_stable (link),
    .link_rise   (link_rise)
  );

  // ****************************************************************
  // receive collection
  // ****************************************************************
  // bytes beyond four are not stored; the count stops at five so long frames never match a command
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_cnt_ff <= 3'h0;
      for (int i = 0; i < CMD_FRAME_LEN; i++) begin
        rx_buf_ff[i] <= 8'h00;
      end
    end else if (link_rise && link.frame_end) begin
      rx_cnt_ff <= 3'h0;
    end else if (link_rise && link.byte_vld) begin
      if (rx_cnt_ff < CMD_FRAME_LEN) begin
        rx_buf_ff[rx_cnt_ff[1:0]] <= link.data;
      end
      if (rx_cnt_ff != RX_CNT_OVER) begin
        rx_cnt_ff <= rx_cnt_ff + 3'h1;
      end
    end
  end

  // frame decode; crc bytes are counted but checked by the modem
  assign frame_done = link_rise && link.frame_end && link.crc_ok     // [RULE_15]
                      && (rx_cnt_ff == CMD_FRAME_LEN) && ctrl_ff[0];
  assign is_hlta = frame_done && (rx_buf_ff[0] == HLTA_CODE_HI)
                   && (rx_buf_ff[1] == HLTA_CODE_LO);                // [RULE_01]
  assign is_rats = frame_done && (rx_buf_ff[0] == RATS_START);        // [RULE_03]

  // ****************************************************************
  // tag state
  // ****************************************************************
  // only a selected tag obeys halt and rats; others ignore them
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TAG_STATE <= ST_IDLE;
    end else begin
      case (TAG_STATE)
        ST_IDLE, ST_HALT: begin
          if (SELECTED) begin
            TAG_STATE <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (is_hlta) begin
            TAG_STATE <= ST_HALT;                                     // [RULE_01]
          end else if (is_rats && rx_buf_ff[1][3:0] == CID_FORBIDDEN) begin
            TAG_STATE <= ST_IDLE;                                     // [RULE_07]
          end else if (is_rats && !TX_QUIET) begin
            TAG_STATE <= ST_PROTOCOL;
          end
        end
        ST_PROTOCOL: begin
          TAG_STATE <= ST_PROTOCOL;  // left only by reset; deselect is handled elsewhere
        end
        default: begin
          TAG_STATE <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // rats parameters
  // ****************************************************************
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      param_ff  <= 8'h00;
      CID       <= 4'h0;
      FSD_BYTES <= 9'h010;
    end else if (TAG_STATE == ST_ACTIVE && is_rats
                 && rx_buf_ff[1][3:0] != CID_FORBIDDEN && !TX_QUIET) begin
      param_ff <= rx_buf_ff[1];
      CID      <= rx_buf_ff[1][3:0];                                  // [RULE_06]
      if (rx_buf_ff[1][7:4] > FSDI_STD_MAX) begin
        FSD_BYTES <= fsd_of(FSDI_256);                                // [RULE_05]
      end else begin
        FSD_BYTES <= fsd_of(rx_buf_ff[1][7:4]);                       // [RULE_04]
      end
    end
  end

  // ****************************************************************
  // quiet time after halt
  // ****************************************************************
  // counted on SYS_CLK so it holds even while the carrier clock stops
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      quiet_cnt_ff <= 32'h0;
      TX_QUIET     <= 1'b0;
    end else if (TAG_STATE == ST_ACTIVE && is_hlta) begin
      quiet_cnt_ff <= 32'(QUIET_CNT);                                 // [RULE_02]
      TX_QUIET     <= 1'b1;
    end else if (quiet_cnt_ff != 32'h0) begin
      quiet_cnt_ff <= quiet_cnt_ff - 32'h1;
      TX_QUIET     <= (quiet_cnt_ff != 32'h1);
    end
  end

  // ****************************************************************
  // ats transmitter
  // ****************************************************************
  // one byte per link period; the modem appends crc_a after the last byte
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_start_ff <= 1'b0;
      tx_busy_ff  <= 1'b0;
      tx_idx_ff   <= 3'h0;
      TX_BYTE     <= 8'h00;
      TX_VLD      <= 1'b0;
      TX_LAST     <= 1'b0;
    end else begin
      if (TAG_STATE == ST_ACTIVE && is_rats && !TX_QUIET
          && rx_buf_ff[1][3:0] != CID_FORBIDDEN) begin
        tx_start_ff <= 1'b1;                                          // [RULE_07]
      end
      if (link_rise) begin
        if (tx_busy_ff && tx_idx_ff != ATS_LAST) begin
          tx_idx_ff <= tx_idx_ff + 3'h1;
          TX_BYTE   <= ats_byte(tx_idx_ff + 3'h1);
          TX_LAST   <= (tx_idx_ff + 3'h1 == ATS_LAST);                // [RULE_14]
        end else if (tx_start_ff) begin
          tx_start_ff <= 1'b0;
          tx_busy_ff  <= 1'b1;
          tx_idx_ff   <= 3'h0;
          TX_BYTE     <= ats_byte(3'h0);
          TX_VLD      <= 1'b1;
          TX_LAST     <= 1'b0;
        end else begin
          tx_busy_ff <= 1'b0;
          TX_VLD     <= 1'b0;
          TX_LAST    <= 1'b0;
          TX_BYTE    <= 8'h00;
        end
      end
    end
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  // control write; the reader's guard time after the ats is its own affair
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_ff <= CTRL_RESET;
    end else if (REG_WR && REG_ADDR == REG_CTRL) begin
      ctrl_ff <= {7'h00, REG_WDATA[0]};
    end
  end

  // read data stands the cycle after the strobe only; unmapped reads give zero
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        REG_CTRL:   REG_RDATA <= ctrl_ff;
        REG_STATUS: REG_RDATA <= {4'h0, tx_busy_ff, TX_QUIET, TAG_STATE};
        REG_PARAM:  REG_RDATA <= param_ff;
        default:    REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ==== sim/thrh_props.sv ====
// concurrent checks on the ports of the halt/rats command handler
// assumes it is bound to every thrh_handler instance by the bind at the foot
`timescale 1ns/1ps
`default_nettype none

module thrh_props
  import thrh_pkg::*;
#(
  parameter int QUIET_CNT = QUIET_CYCLES
)
(
  input wire logic           SYS_CLK,
  input wire logic           RST_N,
  input wire logic [7:0]     TX_BYTE,
  input wire logic           TX_VLD,
  input wire logic           TX_LAST,
  input wire logic           TX_QUIET,
  input wire thrh_state_type TAG_STATE,
  input wire logic [3:0]     CID,
  input wire logic [8:0]     FSD_BYTES
);
  // ******
  // helper logic
  // ******
  logic [31:0] quiet_len_ff;

  // length of the present quiet span; a counter avoids a huge repetition
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) quiet_len_ff <= 32'h0;
    else quiet_len_ff <= TX_QUIET ? quiet_len_ff + 32'h1 : 32'h0;
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // ******
  // quiet span and answer framing
  // ******
  sequence s_ats_start;
    $rose(TX_VLD) ##0 (TX_BYTE == ATS_TL);
  endsequence
  sequence s_step(logic [7:0] prev);
    TX_VLD && $changed(TX_BYTE) && ($past(TX_BYTE) == prev);
  endsequence

  property p_halt_enter; $rose(TX_QUIET) |-> TAG_STATE == ST_HALT; endproperty
  property p_quiet_mute; TX_QUIET |-> !TX_VLD; endproperty
  property p_quiet_len; $fell(TX_QUIET) |-> quiet_len_ff == 32'(QUIET_CNT); endproperty
  property p_ats_head; $rose(TX_VLD) |-> s_ats_start ##0 TAG_STATE == ST_PROTOCOL; endproperty
  property p_ats_t0; s_step(ATS_TL) |-> TX_BYTE == 8'h78; endproperty
  property p_ats_ta; s_step(8'h78) |-> TX_BYTE == 8'h80; endproperty
  property p_ats_tb;
    s_step(8'h80) |-> TX_BYTE[3:0] == 4'h0 && TX_BYTE[7:4] inside {[4'h1:4'hE]};
  endproperty
  property p_ats_len; s_ats_start |-> ##[30:34] TX_LAST; endproperty
  property p_ats_tc; TX_LAST |-> TX_VLD && TX_BYTE == 8'h00; endproperty
  property p_ats_stop; $fell(TX_LAST) |-> !TX_VLD; endproperty
  property p_no_cid15; TX_VLD |-> CID != 4'hF; endproperty
  property p_fsd_legal;
    FSD_BYTES inside {9'h010, 9'h018, 9'h020, 9'h028, 9'h030, 9'h040, 9'h060, 9'h080, 9'h100};
  endproperty

  a_halt_enter: assert property (p_halt_enter) else $error("quiet without halt");
  a_quiet_mute: assert property (p_quiet_mute) else $error("sent while quiet");
  a_quiet_len: assert property (p_quiet_len) else $error("quiet span length");
  a_ats_head: assert property (p_ats_head) else $error("bad first ats byte");
  a_ats_t0: assert property (p_ats_t0) else $error("bad format byte");
  a_ats_ta: assert property (p_ats_ta) else $error("bad rate byte");
  a_ats_tb: assert property (p_ats_tb) else $error("bad timing byte");
  a_ats_len: assert property (p_ats_len) else $error("ats length");
  a_ats_tc: assert property (p_ats_tc) else $error("bad option byte");
  a_ats_stop: assert property (p_ats_stop) else $error("bytes after option");
  a_no_cid15: assert property (p_no_cid15) else $error("answer for cid 15");
  a_fsd_legal: assert property (p_fsd_legal) else $error("odd frame size");
endmodule

bind thrh_handler thrh_props #(.QUIET_CNT(QUIET_CNT)) thrh_props_i (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .TX_BYTE(TX_BYTE), .TX_VLD(TX_VLD), .TX_LAST(TX_LAST),
  .TX_QUIET(TX_QUIET), .TAG_STATE(TAG_STATE), .CID(CID), .FSD_BYTES(FSD_BYTES));
`default_nettype wire

// ==== sim/thrh_reader.sv ====
// reader/writer model: makes the link clock and the received frames
// assumes the modem before the tag reports the crc verdict with frame end
`timescale 1ns/1ps
`default_nettype none

module thrh_reader
  import thrh_pkg::*;
(
  output var logic       link_clk,
  output var logic [7:0] rx_byte,
  output var logic       rx_vld,
  output var logic       rx_end,
  output var logic       rx_crc_ok
);
  // link stands still and low until the first frame
  initial begin
    link_clk = 1'b0;
    rx_byte = 8'hA5;
    rx_vld = 1'b0;
    rx_end = 1'b0;
    rx_crc_ok = 1'b0;
  end

  // one 200 ns link period; lines change only while the clock is low
  task automatic tick(input logic [7:0] b, input logic v, input logic e, input logic g);
    rx_byte = b;
    rx_vld = v;
    rx_end = e;
    rx_crc_ok = g;
    #100 link_clk = 1'b1;
    #100 link_clk = 1'b0;
  endtask

  // four bytes first to last, then frame end; the offset keeps link edges off clock edges
  task automatic frame(input logic [31:0] bytes, input logic good);
    #13;
    for (int i = 3; i >= 0; i--) tick(bytes[i*8 +: 8], 1'b1, 1'b0, 1'b0);
    tick(~bytes[7:0], 1'b0, 1'b1, good);
  endtask

  // carrier periods between frames; the data byte toggles so it never looks stale
  task automatic run(input int n);
    repeat (n) tick(~rx_byte, 1'b0, 1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

// ==== sim/typea_halt_rats_handler_test.sv ====
// self-checking bench for the halt/rats command handler
// assumes the reader model and the bound checker are compiled before it
`timescale 1ns/1ps
`default_nettype none

module typea_halt_rats_handler_test
  import thrh_pkg::*;
;
  localparam int QCNT = 200;
  logic           sys_clk;
  logic           rst_n;
  logic           sel;
  logic           reg_wr;
  logic           reg_rd;
  logic [1:0]     reg_addr;
  logic [7:0]     reg_wdata;
  int             last_at;
  logic           link_clk, rx_vld, rx_end, rx_crc_ok, tx_vld, tx_last, tx_quiet;
  logic [7:0]     rx_byte, reg_rdata, tx_byte, byte_q;
  logic [3:0]     cid;
  logic [8:0]     fsd_bytes;
  thrh_state_type tag_state;
  int             n_mismatch = 0;
  int             compares = 0;
  logic [7:0]     ats_q [$];
  logic           vld_q = 1'b0;
  logic [8:0]     fsd_tab [9] = '{9'h010, 9'h018, 9'h020, 9'h028, 9'h030, 9'h040, 9'h060,
                                  9'h080, 9'h100};

  always #12.5 sys_clk = ~sys_clk;

  thrh_reader thrh_reader_i (.link_clk(link_clk), .rx_byte(rx_byte), .rx_vld(rx_vld),
    .rx_end(rx_end), .rx_crc_ok(rx_crc_ok));
  thrh_handler #(.QUIET_CNT(QCNT)) thrh_handler_i (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .LINK_CLK(link_clk), .RX_BYTE(rx_byte), .RX_BYTE_VLD(rx_vld), .RX_FRAME_END(rx_end),
    .RX_CRC_OK(rx_crc_ok), .SELECTED(sel), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .TX_BYTE(tx_byte),
    .TX_VLD(tx_vld), .TX_LAST(tx_last), .TX_QUIET(tx_quiet), .TAG_STATE(tag_state),
    .CID(cid), .FSD_BYTES(fsd_bytes));

  // collect each answer byte once, in its first cycle
  always @(posedge sys_clk) begin
    if (tx_vld && (!vld_q || tx_byte !== byte_q)) begin
      ats_q.push_back(tx_byte);
      if (tx_last) last_at = ats_q.size();
    end
    vld_q <= tx_vld;
    byte_q <= tx_byte;
  end

  // ******
  // shared tasks
  // ******
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic do_reset;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    ats_q.delete();
    last_at = 0;
  endtask
  task automatic select;
    @(posedge sys_clk);
    sel <= 1'b1;
    @(posedge sys_clk);
    sel <= 1'b0;
    #1;
  endtask
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // ******
  // scenarios
  // ******
  task automatic t_reset;
    logic [7:0] d;
    check(16'(fsd_bytes), 16'h0010);
    check(16'(tag_state), 16'(ST_IDLE));
    reg_read(2'h0, d);
    check(16'(d), 16'h0001);
    reg_write(2'h1, 8'hFF);
    reg_read(2'h1, d);
    check(16'(d), 16'h0000);
    reg_read(2'h3, d);
    check(16'(d), 16'h0000);
  endtask
  task automatic t_halt;
    logic [7:0] d;
    select();
    thrh_reader_i.frame(32'h5000_C1C2, 1'b0);
    thrh_reader_i.run(2);
    check(16'(tag_state), 16'(ST_ACTIVE));
    thrh_reader_i.frame(32'hE080_C1C2, 1'b0);
    thrh_reader_i.run(8);
    check(16'(ats_q.size()), 16'h0000);
    thrh_reader_i.frame(32'h5000_C1C2, 1'b1);
    thrh_reader_i.run(1);
    check(16'(tag_state), 16'(ST_HALT));
    check(16'(tx_quiet), 16'h0001);
    reg_read(2'h1, d);
    check(16'(d), 16'h0005);
    select();
    thrh_reader_i.frame(32'hE080_C1C2, 1'b1);
    thrh_reader_i.run(8);
    check(16'(ats_q.size()), 16'h0000);
    repeat (QCNT) @(posedge sys_clk);
    check(16'(tx_quiet), 16'h0000);
  endtask
  task automatic t_disable;
    reg_write(2'h0, 8'h00);
    thrh_reader_i.frame(32'h5000_C1C2, 1'b1);
    thrh_reader_i.run(2);
    check(16'(tag_state), 16'(ST_ACTIVE));
    reg_write(2'h0, 8'h01);
  endtask
  task automatic t_cid15;
    do_reset();
    select();
    thrh_reader_i.frame(32'hE08F_C1C2, 1'b1);
    thrh_reader_i.run(8);
    check(16'(ats_q.size()), 16'h0000);
    check(16'(tag_state), 16'(ST_IDLE));
  endtask
  task automatic t_rats;
    logic [7:0] d;
    logic [3:0] c;
    logic [7:0] exp [5];
    exp = '{8'h05, 8'h78, 8'h80, {ATS_FWI, 4'h0}, 8'h00};
    for (int f = 0; f < 16; f++) begin
      c = 4'(f % 15);
      do_reset();
      select();
      thrh_reader_i.frame({8'hE0, 4'(f), c, 16'hC1C2}, 1'b1);
      thrh_reader_i.run(8);
      check(16'(tag_state), 16'(ST_PROTOCOL));
      check(16'(cid), 16'(c));
      check(16'(fsd_bytes), 16'((f <= 8) ? fsd_tab[f] : 9'h100));
      reg_read(2'h2, d);
      check(16'(d), 16'({4'(f), c}));
      check(16'(ats_q.size()), 16'h0005);
      check(16'(last_at), 16'h0005);
      for (int k = 0; k < 5; k++) check(16'(ats_q[k]), 16'(exp[k]));
    end
  endtask

  // main sequence
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    sel = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    do_reset();
    t_reset();
    t_halt();
    t_disable();
    t_cid15();
    t_rats();
    end_sim();
  end

  // watchdog, well beyond the expected run of some 70 us
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
